/* File: verilog/emb_port.v */
// External memory bus port: multiplexed code and data bus with strobes
`timescale 1ns/1ps
`include "emb_map.vh"

module emb_port (
    input  wire        clk_sys_in,
    input  wire        rst_in,
    input  wire        fetch_req_in,
    input  wire [15:0] fetch_addr_in,
    output reg         fetch_done_out,
    output reg  [7:0]  fetch_data_out,
    input  wire        data_req_in,
    input  wire        data_write_in,
    input  wire [23:0] data_addr_in,
    input  wire [7:0]  data_wdata_in,
    output reg         data_done_out,
    output reg  [7:0]  data_rdata_out,
    output reg  [12:0] int_code_addr_out,
    input  wire [7:0]  int_code_data_in,
    input  wire [7:0]  low_latch_in,
    input  wire [7:0]  upper_latch_in,
    input  wire        code_source_select_in,
    input  wire [7:0]  low_addr_data_port_in,
    output reg  [7:0]  low_addr_data_port_out,
    output reg  [7:0]  low_addr_data_port_oe_out,
    input  wire [7:0]  upper_addr_port_in,
    output reg  [7:0]  upper_addr_port_out,
    output reg  [7:0]  upper_addr_port_oe_out,
    output reg  [7:0]  upper_pullup_out,
    output reg  [7:0]  low_pins_out,
    output reg  [7:0]  upper_pins_out,
    input  wire        program_fetch_strobe_n_in,
    output reg         program_fetch_strobe_n_out,
    output reg         program_fetch_strobe_n_oe_out,
    output reg         addr_latch_strobe_out,
    output reg         read_strobe_n_out,
    output reg         write_strobe_n_out,
    output reg         download_mode_out
);

    // ****************************************
    // Slot kinds
    // ****************************************
    localparam [1:0] SL_IDLE = 2'h0;
    localparam [1:0] SL_FEXT = 2'h1;
    localparam [1:0] SL_FINT = 2'h2;
    localparam [1:0] SL_DATA = 2'h3;

    // ****************************************
    // Slot state and captured requests
    // ****************************************
    reg [1:0]  slot;
    reg [3:0]  step;
    reg        f_pend;
    reg        d_pend;
    reg [15:0] f_addr;
    reg [23:0] d_addr;
    reg [7:0]  d_wdata;
    reg        d_we;

    // ****************************************
    // Synchroniser and strap state
    // ****************************************
    reg        ea_s1;
    reg        ea_s2;
    reg        program_fetch_strobe_n_s1;
    reg        program_fetch_strobe_n_s2;
    reg [7:0]  p0_s1;
    reg [7:0]  p0_s2;
    reg [7:0]  p2_s1;
    reg [7:0]  p2_s2;
    reg [1:0]  strap_cnt;
    reg        strap_done;

    // ****************************************
    // Slot control
    // ****************************************
    wire [3:0] last_step;
    wire       at_end;
    wire       addr_ph;
    wire       stb_ph;
    wire       may_start;
    wire       take_d;
    wire       take_f;
    wire       fetch_int;

    // ****************************************
    // Next pin values
    // ****************************************
    reg        next_ale;
    reg        next_program_fetch_strobe_n_n;
    reg        next_rd_n;
    reg        next_wr_n;
    reg [7:0]  next_p0_out;
    reg [7:0]  next_p0_oe;
    reg [7:0]  next_p2_out;
    reg [7:0]  next_p2_oe;
    reg [7:0]  next_pullup;

    assign last_step = (slot == SL_DATA) ? `EMB_DATA_LAST : `EMB_FETCH_LAST;
    assign at_end    = (step == last_step);
    assign addr_ph   = (step <= `EMB_ADDR_LAST);
    assign stb_ph    = (step >= `EMB_STB_FIRST);
    assign may_start = strap_done & ~download_mode_out & at_end;
    // Data access wins over a pending fetch
    assign take_d    = may_start & d_pend;
    assign take_f    = may_start & ~d_pend & f_pend;
    // Internal range only when code source select is high
    assign fetch_int = ea_s2 & (f_addr <= `EMB_INT_CODE_TOP);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            ea_s1   <= 1'h0;
            ea_s2   <= 1'h0;
            program_fetch_strobe_n_s1 <= `EMB_STROBE_IDLE;
            program_fetch_strobe_n_s2 <= `EMB_STROBE_IDLE;
        end else begin
            ea_s1   <= code_source_select_in;
            ea_s2   <= ea_s1;
            program_fetch_strobe_n_s1 <= program_fetch_strobe_n_in;
            program_fetch_strobe_n_s2 <= program_fetch_strobe_n_s1;
        end
    end

    // ****************************************
    // Low port readback synchroniser
    // ****************************************
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            p0_s1 <= `EMB_BYTE_RST;
            p0_s2 <= `EMB_BYTE_RST;
        end else begin
            p0_s1 <= low_addr_data_port_in;
            p0_s2 <= p0_s1;
        end
    end

    // ****************************************
    // Upper port readback synchroniser
    // ****************************************
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            p2_s1 <= `EMB_BYTE_RST;
            p2_s2 <= `EMB_BYTE_RST;
        end else begin
            p2_s1 <= upper_addr_port_in;
            p2_s2 <= p2_s1;
        end
    end

    // ****************************************
    // Download strap
    // ****************************************
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            strap_cnt         <= 2'h0;
            strap_done        <= 1'h0;
            download_mode_out <= 1'h0;
        end else if (!strap_done) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == `EMB_STRAP_WAIT) begin
                strap_done        <= 1'h1;
                download_mode_out <= ~program_fetch_strobe_n_s2;
            end
        end
    end

    // ****************************************
    // Request capture
    // ****************************************
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            f_pend  <= 1'h0;
            d_pend  <= 1'h0;
            f_addr  <= 16'h0000;
            d_addr  <= 24'h000000;
            d_wdata <= `EMB_BYTE_RST;
            d_we    <= 1'h0;
        end else begin
            // New request wins over the clear of its pending flag
            f_pend <= fetch_req_in | (f_pend & ~take_f);
            d_pend <= data_req_in | (d_pend & ~take_d);
            if (fetch_req_in) begin
                f_addr <= fetch_addr_in;
            end
            if (data_req_in) begin
                d_addr  <= data_addr_in;
                d_wdata <= data_wdata_in;
                d_we    <= data_write_in;
            end
        end
    end

    // ****************************************
    // Slot sequencing
    // ****************************************
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            slot <= SL_IDLE;
            step <= `EMB_STEP_RST;
        end else begin
            if (!strap_done) begin
                slot <= SL_IDLE;
                step <= `EMB_STEP_RST;
            end else if (at_end) begin
                step <= `EMB_STEP_RST;
                if (take_d) begin
                    slot <= SL_DATA;
                end else if (take_f && fetch_int) begin
                    slot <= SL_FINT;
                end else if (take_f) begin
                    slot <= SL_FEXT;
                end else begin
                    slot <= SL_IDLE;
                end
            end else begin
                step <= step + 4'h1;
            end
        end
    end

    // ****************************************
    // Pin and strobe decode per slot step
    // ****************************************
    always @* begin
        // Address latch strobe at the head of each slot: six periods, twelve for a data slot
        next_ale    = strap_done & (step == `EMB_ALE_STEP);
        next_program_fetch_strobe_n_n = `EMB_STROBE_IDLE;
        next_rd_n   = `EMB_STROBE_IDLE;
        next_wr_n   = `EMB_STROBE_IDLE;
        case (slot)
            SL_FEXT: begin
                next_program_fetch_strobe_n_n = ~(stb_ph & (step <= `EMB_PROGRAM_FETCH_STROBE_N_LAST));
            end
            SL_FINT: begin
                next_program_fetch_strobe_n_n = `EMB_STROBE_IDLE;
            end
            SL_DATA: begin
                next_rd_n   = ~(~d_we & stb_ph &
                                (step <= `EMB_RW_LAST));
                next_wr_n   = ~(d_we & stb_ph &
                                (step <= `EMB_RW_LAST));
                // Fetch strobe pulses are skipped for the whole access
                next_program_fetch_strobe_n_n = `EMB_STROBE_IDLE;
            end
            default: begin
                next_program_fetch_strobe_n_n = `EMB_STROBE_IDLE;
            end
        endcase
    end

    // ****************************************
    // Port drive decode per slot step
    // ****************************************
    always @* begin
        case (slot)
            SL_FEXT: begin
                // Address held one step past the latch strobe fall
                next_p0_out = f_addr[7:0];
                next_p0_oe  = addr_ph ? 8'hFF : 8'h00;
                next_p2_out = f_addr[15:8];
                next_p2_oe  = 8'hFF;
                next_pullup = 8'h00;
            end
            SL_DATA: begin
                next_p0_out = addr_ph ? d_addr[7:0] : d_wdata;
                if (addr_ph) begin
                    next_p0_oe = 8'hFF;
                end else if (d_we && step <= `EMB_WD_LAST) begin
                    next_p0_oe = 8'hFF;
                end else begin
                    next_p0_oe = 8'h00;
                end
                // Page byte while latched, then the middle byte
                next_p2_out = addr_ph ? d_addr[23:16] : d_addr[15:8];
                next_p2_oe  = 8'hFF;
                next_pullup = 8'h00;
            end
            default: begin
                // General I/O: open drain low port, pulled-up upper port
                next_p0_out = `EMB_BYTE_RST;
                next_p0_oe  = ~low_latch_in;
                next_p2_out = `EMB_BYTE_RST;
                next_p2_oe  = ~upper_latch_in;
                next_pullup = upper_latch_in;
            end
        endcase
    end

    // ****************************************
    // Registered pins and strobes
    // ****************************************
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            addr_latch_strobe_out         <= 1'h0;
            program_fetch_strobe_n_out    <= `EMB_STROBE_IDLE;
            program_fetch_strobe_n_oe_out <= 1'h0;
            read_strobe_n_out             <= `EMB_STROBE_IDLE;
            write_strobe_n_out            <= `EMB_STROBE_IDLE;
            low_addr_data_port_out        <= `EMB_BYTE_RST;
            low_addr_data_port_oe_out     <= `EMB_BYTE_RST;
            upper_addr_port_out           <= `EMB_BYTE_RST;
            upper_addr_port_oe_out        <= `EMB_BYTE_RST;
            upper_pullup_out              <= 8'hFF;
        end else begin
            addr_latch_strobe_out      <= next_ale;
            program_fetch_strobe_n_out <= next_program_fetch_strobe_n_n;
            // Strobe pin released until the strap is read
            program_fetch_strobe_n_oe_out <= strap_done;
            read_strobe_n_out          <= next_rd_n;
            write_strobe_n_out         <= next_wr_n;
            low_addr_data_port_out     <= next_p0_out;
            low_addr_data_port_oe_out  <= next_p0_oe;
            upper_addr_port_out        <= next_p2_out;
            upper_addr_port_oe_out     <= next_p2_oe;
            upper_pullup_out           <= next_pullup;
        end
    end

    // ****************************************
    // Registered readback and results
    // ****************************************
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            low_pins_out      <= `EMB_BYTE_RST;
            upper_pins_out    <= `EMB_BYTE_RST;
            fetch_done_out    <= 1'h0;
            fetch_data_out    <= `EMB_BYTE_RST;
            data_done_out     <= 1'h0;
            data_rdata_out    <= `EMB_BYTE_RST;
            int_code_addr_out <= 13'h0000;
        end else begin
            low_pins_out               <= p0_s2;
            upper_pins_out             <= p2_s2;
            int_code_addr_out          <= f_addr[12:0];
            fetch_done_out <= at_end &
                              ((slot == SL_FEXT) | (slot == SL_FINT));
            data_done_out  <= at_end & (slot == SL_DATA);
            if (at_end && slot == SL_FEXT) begin
                fetch_data_out <= p0_s2;
            end else if (at_end && slot == SL_FINT) begin
                fetch_data_out <= int_code_data_in;
            end
            if (slot == SL_DATA && !d_we &&
                step == `EMB_RD_SAMPLE) begin
                data_rdata_out <= p0_s2;
            end
        end
    end

endmodule // emb_port

/* File: verilog/emb_map.vh */
// Constants for the external memory bus port
`ifndef EMB_MAP_VH
`define EMB_MAP_VH

// ****************************************
// Bus slot timing in oscillator periods
// ****************************************
`define EMB_OSC_PERIOD_NS  100
`define EMB_CADENCE_OSC    6
`define EMB_FETCH_LAST     4'h5
`define EMB_DATA_LAST      4'hB
`define EMB_ALE_STEP       4'h0
`define EMB_ADDR_LAST      4'h1
`define EMB_STB_FIRST      4'h2
`define EMB_PROGRAM_FETCH_STROBE_N_LAST      4'h4
`define EMB_RW_LAST        4'h9
`define EMB_WD_LAST        4'hA
`define EMB_RD_SAMPLE      4'hA
`define EMB_STEP_RST       4'h0

// ****************************************
// Address ranges, strap and reset values
// ****************************************
`define EMB_INT_CODE_TOP   16'h1FFF
`define EMB_STRAP_WAIT     2'h3
`define EMB_STROBE_IDLE    1'h1
`define EMB_BYTE_RST       8'h00

`endif

/* File: sim/emb_port_props.sv */
// Concurrent checks on the external memory bus port pins
`timescale 1ns/1ps
module emb_port_props (
    input wire       clk_sys_in,
    input wire       rst_in,
    input wire       addr_latch_strobe_out,
    input wire       program_fetch_strobe_n_out,
    input wire       read_strobe_n_out,
    input wire       write_strobe_n_out,
    input wire [7:0] low_addr_data_port_out,
    input wire [7:0] low_addr_data_port_oe_out,
    input wire [7:0] upper_addr_port_oe_out,
    input wire       download_mode_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    wire ale = addr_latch_strobe_out;
    wire pfs = program_fetch_strobe_n_out;
    wire rd = read_strobe_n_out;
    wire wr = write_strobe_n_out;
    // *****
    // Strobe shapes
    // *****
    sequence s_fetch_low;  !pfs [*3]; endsequence
    sequence s_read_low;   !rd [*8]; endsequence
    sequence s_write_low;  (!wr && low_addr_data_port_oe_out == 8'hFF) [*8];
    endsequence
    property p_fetch_len; $fell(pfs) |-> s_fetch_low ##1 pfs; endproperty
    a_fetch_len: assert property (p_fetch_len)
        else $error("fetch strobe width wrong");
    property p_read_len; $fell(rd) |-> s_read_low ##1 rd; endproperty
    a_read_len: assert property (p_read_len)
        else $error("read strobe width wrong");
    property p_write_len; $fell(wr) |-> s_write_low ##1 wr; endproperty
    a_write_len: assert property (p_write_len)
        else $error("write strobe or data drive wrong");
    property p_addr_first;
        ($fell(pfs) || $fell(rd) || $fell(wr)) |-> $past(ale, 2)
            && $past(low_addr_data_port_oe_out) == 8'hFF
            && $past(low_addr_data_port_out, 2) == $past(low_addr_data_port_out);
    endproperty
    a_addr_first: assert property (p_addr_first)
        else $error("address not stable before strobe");
    property p_ale_cadence; $rose(ale) |-> ##6 (ale || !rd || !wr); endproperty
    a_ale_cadence: assert property (p_ale_cadence)
        else $error("latch strobe cadence wrong");
    property p_ale_once; $rose(ale) |-> ##1 (!ale) [*5]; endproperty
    a_ale_once: assert property (p_ale_once)
        else $error("latch strobe too long");
    property p_fetch_upper; !pfs |-> upper_addr_port_oe_out == 8'hFF;
    endproperty
    a_fetch_upper: assert property (p_fetch_upper)
        else $error("upper port idle in fetch");
    property p_data_quiet; (!rd || !wr) |-> !ale && pfs; endproperty
    a_data_quiet: assert property (p_data_quiet)
        else $error("strobe during data access");
    property p_dl_quiet; download_mode_out |-> pfs && rd && wr; endproperty
    a_dl_quiet: assert property (p_dl_quiet)
        else $error("bus active in download mode");
endmodule // emb_port_props
bind emb_port emb_port_props u_props (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .addr_latch_strobe_out(addr_latch_strobe_out),
    .program_fetch_strobe_n_out(program_fetch_strobe_n_out),
    .read_strobe_n_out(read_strobe_n_out),
    .write_strobe_n_out(write_strobe_n_out),
    .low_addr_data_port_out(low_addr_data_port_out),
    .low_addr_data_port_oe_out(low_addr_data_port_oe_out),
    .upper_addr_port_oe_out(upper_addr_port_oe_out),
    .download_mode_out(download_mode_out));

/* File: sim/emb_mem_model.sv */
// Partner model: address latch with external code and data memory
`timescale 1ns/1ps
module emb_mem_model (
    input  wire       clk_sys_in,
    input  wire       ale_in,
    input  wire       fetch_n_in,
    input  wire       read_n_in,
    input  wire       write_n_in,
    input  wire [7:0] low_pin_in,
    input  wire [7:0] upper_pin_in,
    output wire       drive_out,
    output wire [7:0] data_out
);
    reg  [7:0]  low_lat = 8'h00;
    reg  [7:0]  page_lat = 8'h00;
    reg  [7:0]  wdata = 8'h00;
    reg  [23:0] waddr = 24'hFFFFFF;
    wire [23:0] addr = {page_lat, upper_pin_in, low_lat};
    always @(posedge clk_sys_in) begin
        if (ale_in) begin
            low_lat  <= low_pin_in;
            page_lat <= upper_pin_in;
        end
        if (!write_n_in) begin
            waddr <= addr;
            wdata <= low_pin_in;
        end
    end
    assign drive_out = !fetch_n_in || !read_n_in;
    // Miss returns inverse so a wrong page shows
    assign data_out = !fetch_n_in ? low_lat ^ upper_pin_in ^ 8'h3C
                    : (addr == waddr) ? wdata : ~wdata;
endmodule // emb_mem_model

/* File: sim/testbench.sv */
// Self-checking bench for the external memory bus port
`timescale 1ns/1ps
module testbench;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         freq = 1'b0;
    reg  [15:0] faddr = 16'h0000;
    reg         dreq = 1'b0;
    reg         dwr = 1'b0;
    reg  [23:0] daddr = 24'h000000;
    reg  [7:0]  wdat = 8'h00;
    reg  [7:0]  llat = 8'hFF;
    reg  [7:0]  ulat = 8'hFF;
    reg         sel = 1'b0;
    reg         strap = 1'b0;
    reg  [7:0]  ext_lo = 8'hA5;
    reg  [7:0]  ext_up = 8'hFE;
    wire [7:0]  lo_o, lo_oe, up_o, up_oe, pu, lpins, upins, rdat, fdat, mdat;
    wire [12:0] iaddr;
    wire [7:0]  icode = iaddr[7:0] ^ 8'h5A;
    wire        fdone, ddone, pfs_o, pfs_oe, ale, rd_n, wr_n, dl, mdrv;
    wire [7:0]  lo_pin = (lo_oe & lo_o) | (~lo_oe & (mdrv ? mdat : ext_lo));
    wire [7:0]  up_pin = (up_oe & up_o) | (~up_oe & ext_up);
    wire        pfs_pin = pfs_oe ? pfs_o : ~strap;
    integer     mismatches = 0;
    integer     samples_checked = 0;
    integer     falls = 0;
    integer     dn = 0;
    emb_port u_dut (.clk_sys_in(clk), .rst_in(rst), .fetch_req_in(freq),
        .fetch_addr_in(faddr), .fetch_done_out(fdone), .fetch_data_out(fdat),
        .data_req_in(dreq), .data_write_in(dwr), .data_addr_in(daddr),
        .data_wdata_in(wdat), .data_done_out(ddone), .data_rdata_out(rdat),
        .int_code_addr_out(iaddr), .int_code_data_in(icode),
        .low_latch_in(llat), .upper_latch_in(ulat),
        .code_source_select_in(sel), .low_addr_data_port_in(lo_pin),
        .low_addr_data_port_out(lo_o), .low_addr_data_port_oe_out(lo_oe),
        .upper_addr_port_in(up_pin), .upper_addr_port_out(up_o),
        .upper_addr_port_oe_out(up_oe), .upper_pullup_out(pu),
        .low_pins_out(lpins), .upper_pins_out(upins),
        .program_fetch_strobe_n_in(pfs_pin),
        .program_fetch_strobe_n_out(pfs_o),
        .program_fetch_strobe_n_oe_out(pfs_oe),
        .addr_latch_strobe_out(ale), .read_strobe_n_out(rd_n),
        .write_strobe_n_out(wr_n), .download_mode_out(dl));
    emb_mem_model u_mem (.clk_sys_in(clk), .ale_in(ale), .fetch_n_in(pfs_pin),
        .read_n_in(rd_n), .write_n_in(wr_n), .low_pin_in(lo_pin),
        .upper_pin_in(up_pin), .drive_out(mdrv), .data_out(mdat));
    initial forever #50 clk = ~clk;
    always @(negedge pfs_pin) falls = falls + 1;
    always @(posedge clk) if (fdone === 1'b1) dn = dn + 1;
    task tick; begin @(posedge clk); #1; end endtask
    task cmp8(input [7:0] got, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task cmp1(input got, input exp); cmp8({7'h00, got}, {7'h00, exp});
    endtask
    task finish_test;
        begin
            $display("checked %0d mismatches %0d", samples_checked, mismatches);
            if (mismatches == 0 && samples_checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task wait_for(input d);
        integer n;
        begin
            n = 0;
            while (n < 60 && (d ? ddone : fdone) !== 1'b1) begin
                tick;
                n = n + 1;
            end
            if (n == 60) begin
                mismatches = mismatches + 1;
                $display("BAD %0t no done", $time);
                finish_test;
            end
        end
    endtask
    task do_reset(input s);
        begin
            strap = s;
            rst = 1'b1;
            repeat (6) tick;
            rst = 1'b0;
            repeat (12) tick;
            strap = 1'b0;
            falls = 0;
            dn = 0;
        end
    endtask
    task do_fetch(input [15:0] a, input s, input [7:0] exp, input [7:0] nf);
        begin
            sel = s;
            repeat (3) tick;
            falls = 0;
            faddr = a;
            freq = 1'b1;
            tick;
            freq = 1'b0;
            wait_for(1'b0);
            cmp8(fdat, exp);
            cmp8(falls[7:0], nf);
        end
    endtask
    task do_data(input w, input [23:0] a, input [7:0] d);
        begin
            dwr = w;
            daddr = a;
            wdat = d;
            dreq = 1'b1;
            tick;
            dreq = 1'b0;
            wait_for(1'b1);
        end
    endtask
    task t_download;
        begin
            do_reset(1'b1);
            cmp1(dl, 1'b1);
            faddr = 16'h0040;
            freq = 1'b1;
            tick;
            freq = 1'b0;
            repeat (40) tick;
            cmp8(dn[7:0], 8'h00);
            cmp8(falls[7:0], 8'h00);
        end
    endtask
    task t_fetch;
        begin
            do_reset(1'b0);
            cmp1(dl, 1'b0);
            do_fetch(16'h0123, 1'b0, 8'h1E, 8'h01);
            do_fetch(16'h1FFF, 1'b1, 8'hA5, 8'h00);
            cmp8(iaddr[7:0], 8'hFF);
            do_fetch(16'h2000, 1'b1, 8'h1C, 8'h01);
        end
    endtask
    task t_data;
        begin
            do_data(1'b1, 24'h5A3C71, 8'hC3);
            do_data(1'b0, 24'h5A3C71, 8'h00);
            cmp8(rdat, 8'hC3);
            do_data(1'b0, 24'h5B3C71, 8'h00);
            cmp8(rdat, 8'h3C);
            do_data(1'b0, 24'h5A3D71, 8'h00);
            cmp8(rdat, 8'h3C);
        end
    endtask
    task t_gpio;
        begin
            llat = 8'hF0;
            ulat = 8'h0F;
            repeat (8) tick;
            cmp8(lo_oe, 8'h0F);
            cmp8(lpins, 8'hA0);
            cmp8(up_oe, 8'hF0);
            cmp8(pu, 8'h0F);
            cmp8(upins, 8'h0E);
        end
    endtask
    initial begin
        t_download;
        t_fetch;
        t_data;
        t_gpio;
        finish_test;
    end
endmodule // testbench
